// ---- rtl/fcb_pkg.sv ----
// constants for the channel-b equalizer coefficient bank
// assumes a 32-bit wishbone register bus and a 12-bit sample stream
package fcb_pkg;

  // ----------------------------------------------------------------
  // filter shape
  // ----------------------------------------------------------------
  localparam int NTAPS = 9;
  localparam int CENTER = 4;
  localparam int SMP_W = 12;
  localparam int TAP_W = 12;
  localparam int CTR_W = 18;
  localparam int PROD_W = SMP_W + CTR_W;
  localparam int OUT_W = PROD_W + 4;
  localparam int TAP_MSB = 11;
  localparam int CTR_MSB = 17;
  localparam int REG_W = 24;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_TAP [NTAPS] = '{
    12'h448, 12'h44A, 12'h44C, 12'h44E, 12'h450,
    12'h453, 12'h455, 12'h457, 12'h459};
  localparam logic [11:0] IDX_CTRL = 12'h45B;
  localparam logic [11:0] IDX_STAT = 12'h45C;
  localparam int CTRL_DUAL_BIT = 0;
  localparam int STAT_DUAL_BIT = 0;
  localparam int STAT_VLD_BIT = 1;
  localparam int STAT_CNT_LSB = 2;

  // ----------------------------------------------------------------
  // implemented bits and reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] TAP_MASK = 24'h00FFFF;
  localparam logic [REG_W-1:0] CTR_MASK = 24'hFFFFFF;
  localparam logic [REG_W-1:0] TAP_RST = 24'h000000;
  localparam logic CTRL_RST = 1'h0;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } fcb_bus_e;

endpackage

// ---- rtl/fcb_coef_if.sv ----
// carrier between register file and multiply-accumulate datapath
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface fcb_coef_if;
  logic [fcb_pkg::NTAPS-1:0][fcb_pkg::CTR_W-1:0] coef;
  logic en;
  logic [fcb_pkg::SMP_W-1:0] smp;
  logic smp_valid;
  logic [fcb_pkg::OUT_W-1:0] flt;
  logic flt_valid;
  modport ctl (output coef, output en, output smp, output smp_valid,
               input flt, input flt_valid);
  modport dp (input coef, input en, input smp, input smp_valid,
              output flt, output flt_valid);
endinterface

// ---- rtl/fcb_mac.sv ----
// nine-tap multiply-accumulate datapath for channel b
// assumes coefficients already sign-extended to the center width
`timescale 1ns/10ps
module fcb_mac (
  input wire logic clk_i,
  input wire logic rst_i,
  fcb_coef_if.dp cif
);

  typedef struct packed {
    logic [fcb_pkg::NTAPS-1:0][fcb_pkg::SMP_W-1:0] line;
    logic [fcb_pkg::OUT_W-1:0] acc;
    logic vld;
  } fcb_mac_s;

  fcb_mac_s st;
  fcb_mac_s next_st;

  // ----------------------------------------------------------------
  // delay line and sum of products
  // ----------------------------------------------------------------
  // products kept at full width so no bit is lost before scaling
  always_comb
  begin
    logic signed [fcb_pkg::PROD_W-1:0] prod;
    logic [fcb_pkg::OUT_W-1:0] sum;
    prod = '0;
    sum = '0;
    next_st = st;
    next_st.vld = 1'b0;
    if (cif.smp_valid)
    begin
      next_st.line = {st.line[fcb_pkg::NTAPS-2:0], cif.smp};
      for (int k = 0; k < fcb_pkg::NTAPS; k++)
      begin
        prod = $signed(next_st.line[k]) * $signed(cif.coef[k]);
        sum = sum + {{4{prod[fcb_pkg::PROD_W-1]}}, prod};
      end
      next_st.acc = sum;
      next_st.vld = cif.en;
    end
    // in single-channel use this set must not reach the output
    if (!cif.en)
    begin
      next_st.acc = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign cif.flt = st.acc;
  assign cif.flt_valid = st.vld;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_mac_valid;
    @(posedge clk_i) disable iff (rst_i)
    cif.smp_valid && cif.en |=> cif.flt_valid;
  endproperty
  a_mac_valid: assert property (p_mac_valid)
    else $error("sample taken but no filter output");

  property p_mac_off;
    @(posedge clk_i) disable iff (rst_i)
    !cif.en |=> !cif.flt_valid && cif.flt == '0;
  endproperty
  a_mac_off: assert property (p_mac_off)
    else $error("output produced while channel b disabled");

  property p_mac_hold;
    @(posedge clk_i) disable iff (rst_i)
    cif.en && !cif.smp_valid |=> !cif.flt_valid;
  endproperty
  a_mac_hold: assert property (p_mac_hold)
    else $error("output valid without an input sample");

endmodule

// ---- rtl/fcb_top.sv ----
// channel-b equalizer coefficient bank with wishbone register access
// assumes samples arrive on clk_i and a classic wishbone master
//
// Overview of operation
// - non-center taps: signed 12-bit in bits 11:0, bits 15:12 reserved.
// - center tap is signed 18-bit in bits 17:0, bits 23:18 reserved.
// - channel-b weights act only on the channel-b filter in dual mode.
// - index 0x448..0x450 then 0x453 hold taps one to six in order.
// - all tap registers incl. reserved bits read/write, reset to zero.
// - in single-channel mode the channel-b weights have no effect.
`timescale 1ns/10ps
module fcb_top #(
  parameter int ADR_W = 16,
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [fcb_pkg::SMP_W-1:0] smp_i,
  input wire logic smp_valid_i,
  output logic [fcb_pkg::OUT_W-1:0] flt_o,
  output logic flt_valid_o,
  output logic dual_mode_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    fcb_pkg::fcb_bus_e bus;
    logic ack;
    logic [31:0] rdata;
    logic [fcb_pkg::NTAPS-1:0][fcb_pkg::REG_W-1:0] tap;
    logic dual;
    logic [CNT_W-1:0] outs;
  } fcb_top_s;

  fcb_top_s st;
  fcb_top_s next_st;
  fcb_coef_if cif ();

  logic [ADR_W-3:0] widx;
  logic [3:0] hit_tap;

  assign widx = adr_i[ADR_W-1:2];
  assign hit_tap = tap_of(widx);

  // ----------------------------------------------------------------
  // address decoding
  // ----------------------------------------------------------------
  // returns NTAPS when the word index is not a tap register
  function automatic logic [3:0] tap_of(input logic [ADR_W-3:0] idx);
    logic [3:0] r;
    r = 4'(fcb_pkg::NTAPS);
    for (int t = 0; t < fcb_pkg::NTAPS; t++)
    begin
      if (idx == (ADR_W-2)'(fcb_pkg::IDX_TAP[t]))
        r = 4'(t);
    end
    return r;
  endfunction

  // implemented bits per tap; reserved bits are stored too
  function automatic logic [fcb_pkg::REG_W-1:0] mask_of(
    input logic [3:0] t);
    logic [fcb_pkg::REG_W-1:0] m;
    m = fcb_pkg::TAP_MASK;
    if (t == 4'(fcb_pkg::CENTER))
      m = fcb_pkg::CTR_MASK;
    return m;
  endfunction

  // ----------------------------------------------------------------
  // bus slave and register file
  // ----------------------------------------------------------------
  // one wait state: ack rises the cycle after strobe, then drops
  always_comb
  begin
    logic [fcb_pkg::REG_W-1:0] m;
    m = '0;
    next_st = st;
    next_st.ack = 1'b0;
    if (cif.flt_valid)
      next_st.outs = st.outs + CNT_W'(1);
    case (st.bus)
      fcb_pkg::BUS_IDLE:
      begin
        if (cyc_i && stb_i)
        begin
          next_st.bus = fcb_pkg::BUS_ACK;
          next_st.ack = 1'b1;
          next_st.rdata = '0;
          if (hit_tap != 4'(fcb_pkg::NTAPS))
          begin
            m = mask_of(hit_tap);
            if (we_i)
            begin
              // byte lanes beyond the register width are dropped
              for (int b = 0; b < 3; b++)
              begin
                if (sel_i[b])
                  next_st.tap[hit_tap][8*b+:8] =
                    dat_i[8*b+:8] & m[8*b+:8];
              end
            end
            else
              next_st.rdata = {8'h00, st.tap[hit_tap] & m};
          end
          else if (widx == (ADR_W-2)'(fcb_pkg::IDX_CTRL))
          begin
            if (we_i && sel_i[0])
              next_st.dual = dat_i[fcb_pkg::CTRL_DUAL_BIT];
            else if (!we_i)
              next_st.rdata[fcb_pkg::CTRL_DUAL_BIT] = st.dual;
          end
          else if (widx == (ADR_W-2)'(fcb_pkg::IDX_STAT))
          begin
            // status is read-only; writes are acknowledged and dropped
            if (!we_i)
            begin
              next_st.rdata[fcb_pkg::STAT_DUAL_BIT] = st.dual;
              next_st.rdata[fcb_pkg::STAT_VLD_BIT] = cif.flt_valid;
              next_st.rdata[fcb_pkg::STAT_CNT_LSB+:CNT_W] = st.outs;
            end
          end
          // unmapped: acknowledged, reads zero, writes ignored
        end
      end
      fcb_pkg::BUS_ACK:
      begin
        next_st.bus = fcb_pkg::BUS_IDLE;
      end
      default:
      begin
        next_st.bus = fcb_pkg::BUS_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.bus <= fcb_pkg::BUS_IDLE;
      st.dual <= fcb_pkg::CTRL_RST;
      for (int t = 0; t < fcb_pkg::NTAPS; t++)
        st.tap[t] <= fcb_pkg::TAP_RST;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // coefficient fan-out to the datapath
  // ----------------------------------------------------------------
  // reserved bits never reach the multipliers
  genvar g;
  generate
    for (g = 0; g < fcb_pkg::NTAPS; g++)
    begin : g_coef
      if (g == fcb_pkg::CENTER)
      begin : g_ctr
        assign cif.coef[g] = st.tap[g][fcb_pkg::CTR_MSB:0];
      end
      else
      begin : g_side
        assign cif.coef[g] = {
          {(fcb_pkg::CTR_W-fcb_pkg::TAP_W){st.tap[g][fcb_pkg::TAP_MSB]}},
          st.tap[g][fcb_pkg::TAP_MSB:0]};
      end
    end
  endgenerate

  // the channel-b set only runs in dual-channel operation
  assign cif.en = st.dual;
  assign cif.smp = smp_i;
  assign cif.smp_valid = smp_valid_i;

  fcb_mac u_mac (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cif(cif)
  );

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  assign dat_o = st.rdata;
  assign ack_o = st.ack;
  assign flt_o = cif.flt;
  assign flt_valid_o = cif.flt_valid;
  assign dual_mode_o = st.dual;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence

  sequence s_ack_pulse;
    ack_o ##1 !ack_o;
  endsequence

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    s_req |=> s_ack_pulse;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("bus ack not a single cycle after request");

  property p_reset_zero;
    @(posedge clk_i)
    rst_i |=> cif.coef == '0 && !dual_mode_o && dat_o == 32'h00000000;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("coefficients not zero after reset");

  // a full write to tap one reaches the datapath sign-extended
  property p_tap_ext;
    @(posedge clk_i) disable iff (rst_i)
    s_req and (we_i && hit_tap == 4'h0 && sel_i == 4'hF)
    |=> cif.coef[0] == {{6{$past(dat_i[11])}}, $past(dat_i[11:0])};
  endproperty
  a_tap_ext: assert property (p_tap_ext)
    else $error("side tap not sign-extended from bit 11");

  property p_center_ext;
    @(posedge clk_i) disable iff (rst_i)
    s_req and (we_i && hit_tap == 4'(fcb_pkg::CENTER) && sel_i == 4'hF)
    |=> cif.coef[fcb_pkg::CENTER] == $past(dat_i[17:0]);
  endproperty
  a_center_ext: assert property (p_center_ext)
    else $error("center tap weight not taken from bits 17:0");

  property p_write_map;
    @(posedge clk_i) disable iff (rst_i)
    s_req and (we_i && widx == (ADR_W-2)'(12'h453) && sel_i == 4'hF)
    |=> cif.coef[5] == {{6{$past(dat_i[11])}}, $past(dat_i[11:0])};
  endproperty
  a_write_map: assert property (p_write_map)
    else $error("write to sixth tap index did not reach tap six");

  property p_dual_gate;
    @(posedge clk_i) disable iff (rst_i)
    !dual_mode_o ##1 !dual_mode_o |-> !flt_valid_o;
  endproperty
  a_dual_gate: assert property (p_dual_gate)
    else $error("channel-b output while not in dual mode");

  // a write stores exactly the implemented lanes of a side tap
  property p_side_store;
    @(posedge clk_i) disable iff (rst_i)
    s_req and (we_i && hit_tap == 4'h1 && sel_i == 4'hF)
    |=> st.tap[1] == {8'h00, $past(dat_i[15:0])};
  endproperty
  a_side_store: assert property (p_side_store)
    else $error("side tap did not keep exactly sixteen bits");

  // a tap read returns the stored word, reserved bits included
  property p_read_tap;
    @(posedge clk_i) disable iff (rst_i)
    s_req and (!we_i && hit_tap != 4'(fcb_pkg::NTAPS))
    |=> dat_o == {8'h00, $past(st.tap[hit_tap])};
  endproperty
  a_read_tap: assert property (p_read_tap)
    else $error("tap read data differs from stored weight");

  // the dual-channel bit follows a control write one cycle later
  property p_ctrl_write;
    @(posedge clk_i) disable iff (rst_i)
    s_req and (we_i && widx == (ADR_W-2)'(fcb_pkg::IDX_CTRL) && sel_i[0])
    |=> dual_mode_o == $past(dat_i[fcb_pkg::CTRL_DUAL_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("dual-channel bit did not follow control write");

  // ack never appears without a request being taken
  property p_ack_cause;
    @(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i) && !ack_o |=> !ack_o;
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("bus ack without a request");

  // an unmapped write must not disturb any weight
  property p_unmapped;
    @(posedge clk_i) disable iff (rst_i)
    s_req and (we_i && hit_tap == 4'(fcb_pkg::NTAPS)) |=> $stable(st.tap);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("write outside the tap map changed a weight");

endmodule

// ---- test/fcb_smp_src.sv ----
// sample source standing in for the channel-b converter core
// assumes the bench raises req_i just after a rising edge of clk_i
`timescale 1ns/10ps
module fcb_smp_src (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [11:0] dat_i,
  output logic [11:0] smp_o,
  output logic smp_valid_o
);
  // one sample per request; between samples the bus toggles, so a
  // design that reads a stale sample cannot pass by luck
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      smp_o <= 12'h000;
      smp_valid_o <= 1'b0;
    end
    else
    begin
      smp_valid_o <= req_i;
      smp_o <= req_i ? dat_i : ~smp_o;
    end
  end
endmodule

// ---- test/fcb_top_tb.sv ----
// self-checking bench for the channel-b coefficient bank
// assumes fcb_pkg, the design and the sample source are compiled first
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("BAD t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module fcb_top_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] adr_i = 16'h0000;
  logic [31:0] dat_i = 32'h00000000;
  logic [3:0] sel_i = 4'h0;
  logic we_i = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic req = 1'b0;
  logic [11:0] req_dat = 12'h000;
  logic [31:0] dat_o;
  logic ack_o;
  logic [11:0] smp;
  logic smp_valid;
  logic [fcb_pkg::OUT_W-1:0] flt_o;
  logic flt_valid_o;
  logic dual_mode_o;
  logic [23:0] tapv [fcb_pkg::NTAPS];
  logic [31:0] rd;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;

  always #5 clk_i = ~clk_i;

  fcb_top #(.ADR_W(16), .CNT_W(16)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .smp_i(smp), .smp_valid_i(smp_valid), .flt_o(flt_o),
    .flt_valid_o(flt_valid_o), .dual_mode_o(dual_mode_o));
  fcb_smp_src src (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
    .dat_i(req_dat), .smp_o(smp), .smp_valid_o(smp_valid));

  task automatic test_done();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // a hung handshake ends the run here instead of spinning forever
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      test_done();
    end
  end

  // ------------------------------------------------------------------
  // bus and sample helpers
  // ------------------------------------------------------------------
  // classic cycle: hold everything until ack is seen, then one idle cycle
  task automatic wb(input logic we, input logic [11:0] idx,
                    input logic [31:0] wd, input logic [3:0] sel);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    adr_i <= 16'({idx, 2'b00});
    dat_i <= wd;
    sel_i <= sel;
    // no local limit: only the cycle ceiling ends a hung handshake
    do
    begin
      @(posedge clk_i);
    end
    while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  // one sample through the source; answer comes two edges after req
  task automatic smp_go(input logic [11:0] x, input logic on,
                        input logic chk, input logic [33:0] e);
    int n;
    @(posedge clk_i);
    req <= 1'b1;
    req_dat <= x;
    @(posedge clk_i);
    req <= 1'b0;
    for (n = 0; n < 4 && flt_valid_o !== 1'b1; n++)
      @(posedge clk_i);
    `CHK(flt_valid_o, on)
    if (chk)
      `CHK(flt_o, e)
  endtask

  // weight times sample, only the signed field counts, reserved ignored
  function automatic logic [33:0] prod(input int k, input logic [11:0] x);
    longint c;
    c = (k == fcb_pkg::CENTER) ? longint'($signed(tapv[k][17:0]))
                               : longint'($signed(tapv[k][11:0]));
    return 34'(c * longint'($signed(x)));
  endfunction

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  // taps one to six start at zero, then keep exactly their own width
  task automatic t_tap_rw();
    for (int k = 0; k < 6; k++)
    begin
      wb(1'b0, fcb_pkg::IDX_TAP[k], 32'h0, 4'hF);
      `CHK(rd, 32'h0)
      wb(1'b1, fcb_pkg::IDX_TAP[k], {8'hFF,
         (k == 4) ? tapv[k][23:16] : 8'hFF, tapv[k][15:0]}, 4'hF);
      wb(1'b0, fcb_pkg::IDX_TAP[k], 32'h0, 4'hF);
      `CHK(rd, {8'h00, tapv[k]})
    end
  endtask

  // a single byte lane leaves the other lane of the weight alone
  task automatic t_byte_lane();
    wb(1'b1, fcb_pkg::IDX_TAP[3], 32'h0000AB00, 4'h2);
    tapv[3] = 24'h00AB23;
    wb(1'b0, fcb_pkg::IDX_TAP[3], 32'h0, 4'hF);
    `CHK(rd, {8'h00, tapv[3]})
  endtask

  // an index outside the map acks, reads zero and stores nothing
  task automatic t_unmapped();
    wb(1'b1, 12'h000, 32'hFFFFFFFF, 4'hF);
    wb(1'b0, 12'h000, 32'h0, 4'hF);
    `CHK(rd, 32'h0)
  endtask

  // single-channel mode: weights loaded but no channel-b output
  task automatic t_single();
    for (int k = 0; k < 3; k++)
      smp_go(12'h800, 1'b0, 1'b1, 34'h0);
  endtask

  // dual mode: flush the history, walk an impulse through every
  // position, then read back the control and status words
  task automatic t_impulse();
    logic [31:0] st_exp;
    st_exp = 32'(8 + fcb_pkg::NTAPS) << fcb_pkg::STAT_CNT_LSB;
    st_exp[fcb_pkg::STAT_DUAL_BIT] = 1'b1;
    wb(1'b1, fcb_pkg::IDX_CTRL, 32'h1, 4'hF);
    `CHK(dual_mode_o, 1'b1)
    for (int k = 0; k < 8; k++)
      smp_go(12'h000, 1'b1, 1'b0, 34'h0);
    for (int k = 0; k < fcb_pkg::NTAPS; k++)
      smp_go((k == 0) ? 12'h800 : 12'h000, 1'b1, 1'b1,
             prod(k, 12'h800));
    wb(1'b0, fcb_pkg::IDX_CTRL, 32'h0, 4'hF);
    `CHK(rd, 32'h1 << fcb_pkg::CTRL_DUAL_BIT)
    // eight flush samples and nine impulse samples were counted
    wb(1'b0, fcb_pkg::IDX_STAT, 32'h0, 4'hF);
    `CHK(rd, st_exp)
  endtask

  // leaving dual mode silences the channel-b output again
  task automatic t_dual_off();
    wb(1'b1, fcb_pkg::IDX_CTRL, 32'h0, 4'hF);
    smp_go(12'h7FF, 1'b0, 1'b1, 34'h0);
  endtask

  // a reset in mid-run clears taps one to six and the mode bit again
  task automatic t_mid_reset();
    wb(1'b1, fcb_pkg::IDX_CTRL, 32'h1, 4'hF);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK({ack_o, flt_valid_o, dual_mode_o, flt_o}, 37'h0)
    for (int k = 0; k < 6; k++)
    begin
      wb(1'b0, fcb_pkg::IDX_TAP[k], 32'h0, 4'hF);
      `CHK(rd, 32'h0)
    end
  endtask

  initial
  begin
    tapv = '{24'h00F801, 24'h0007FF, 24'h00FFFF, 24'h000123, 24'hFE0000,
             24'h000800, 24'h0, 24'h0, 24'h0};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK({ack_o, flt_valid_o, dual_mode_o}, 3'b000)
    t_tap_rw();
    t_byte_lane();
    t_unmapped();
    t_single();
    t_impulse();
    t_dual_off();
    t_mid_reset();
    test_done();
  end
endmodule
